//--- hdl/axsf_pkg.sv
package axsf_pkg;
   // ****************************************
   // register map (printed offsets 0x06, 0x07 are indices)
   // ****************************************
   localparam logic [3:0] AXSF_IDX_CONFIG = 4'h6;
   localparam logic [3:0] AXSF_IDX_IDENT = 4'h7;
   localparam logic [3:0] AXSF_IDX_CTRL = 4'h8;
   localparam logic [3:0] AXSF_IDX_IRQ_STAT = 4'h9;
   localparam logic [3:0] AXSF_IDX_IRQ_EN = 4'ha;
   localparam logic [3:0] AXSF_IDX_IRQ_CLR = 4'hb;
   localparam logic [15:0] AXSF_CONFIG_RESET = 16'h0800;
   localparam logic [15:0] AXSF_CONFIG_WMASK = 16'h0fff;
   // ****************************************
   // field positions of aux_io_configuration
   // ****************************************
   localparam int AXSF_B_HOLD_EN = 11;
   localparam int AXSF_B_FAULT_FN_HI = 10;
   localparam int AXSF_B_FAULT_FN_LO = 9;
   localparam int AXSF_B_FAULT_LEVEL = 8;
   localparam int AXSF_B_OUT3 = 7;
   localparam int AXSF_B_OUT2 = 6;
   localparam int AXSF_B_IN_SEL1 = 5;
   localparam int AXSF_B_IN_SEL0 = 4;
   localparam int AXSF_B_OUT_SEL1 = 3;
   localparam int AXSF_B_OUT_SEL0 = 2;
   localparam int AXSF_B_LEVEL1 = 1;
   localparam int AXSF_B_LEVEL0 = 0;
   // control register (own): bit0 per_channel_hold_mode, bit1 multi_channel
   localparam int AXSF_B_PER_CH_HOLD = 0;
   localparam int AXSF_B_MULTI_CH = 1;
   // irq bits: 0 hold asserted, 1 fault flag rose, 2 switch stalled
   localparam int AXSF_IRQ_W = 3;
   typedef enum logic [1:0] {
      AXSF_FN_OFF = 2'b00,
      AXSF_FN_INPUT = 2'b01,
      AXSF_FN_WIRED_OR = 2'b10,
      AXSF_FN_GPO = 2'b11
   } axsf_fault_fn_t;
endpackage

//--- hdl/axsf_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - hold enable set: low hold resets modulator
// - per-channel mode: no immediate reset, multi-channel only
// - held pin at switch blocks new conversion
// - hold pin high releases, next conversion starts
// - fault function resets zero, 00 disables
// - 01: inverted pin ORed into fault flag
// - 01: pin level readable via level bit
// - 10: open-drain inverted OR of errors
// - 11: push-pull output follows level bit
// - level bit drives output, reads input
// - bits 7,6 write-only levels of outputs 3,2
// - bits 5,4 select input, reset zero
// - bits 3,2 select output, reset zero
// - bits 1,0 output level or readback
// - identity register read-only fixed code
// - configuration register resets to 0x0800
module axsf_top
   import axsf_pkg::*;
#(
   // arbitrary neutral value
   parameter logic [15:0] PART_CODE = 16'h5a10
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core
   input wire logic core_error,
   input wire logic channel_switch_due,
   output logic core_reset,
   output logic conversion_start,
   output logic fault_status,
   // hold pin
   input wire logic hold_n_in,
   // fault pin
   input wire logic fault_in,
   output logic fault_out,
   output logic fault_oe,
   // output-only pins
   output logic aux_out3,
   output logic aux_out2,
   // bidirectional pins
   input wire logic aux_bidir1_in,
   input wire logic aux_bidir0_in,
   output logic aux_bidir1_out,
   output logic aux_bidir0_out,
   output logic aux_bidir1_oe,
   output logic aux_bidir0_oe,
   // interrupt
   output logic irq
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   always_ff @(posedge clk) begin
      sync1_q <= {hold_n_in, fault_in, aux_bidir1_in, aux_bidir0_in};
      sync2_q <= sync1_q;
   end
   wire logic hold_n_s = sync2_q[3];
   wire logic fault_s = sync2_q[2];
   wire logic bidir1_s = sync2_q[1];
   wire logic bidir0_s = sync2_q[0];

   // ****************************************
   // apb decode
   // ****************************************
   logic [15:0] config_q;
   logic [1:0] ctrl_q;
   logic [AXSF_IRQ_W-1:0] irq_stat_q;
   logic [AXSF_IRQ_W-1:0] irq_en_q;
   wire logic [3:0] reg_idx = paddr[5:2];
   wire logic access = psel && penable;
   // act once, at the edge ending the first access cycle; unmapped is ignored
   wire logic wr = access && pwrite && !pready && mapped;
   wire logic rd = access && !pwrite && !pready && mapped;
   wire logic hit_cfg = reg_idx == AXSF_IDX_CONFIG;
   wire logic hit_id = reg_idx == AXSF_IDX_IDENT;
   wire logic hit_ctrl = reg_idx == AXSF_IDX_CTRL;
   wire logic hit_stat = reg_idx == AXSF_IDX_IRQ_STAT;
   wire logic hit_en = reg_idx == AXSF_IDX_IRQ_EN;
   wire logic hit_clr = reg_idx == AXSF_IDX_IRQ_CLR;
   wire logic mapped = (hit_cfg || hit_id || hit_ctrl || hit_stat || hit_en || hit_clr) && paddr[1:0] == 2'h0;

   // ****************************************
   // pin configuration
   // ****************************************
   wire axsf_fault_fn_t fault_fn = axsf_fault_fn_t'(config_q[AXSF_B_FAULT_FN_HI:AXSF_B_FAULT_FN_LO]);
   wire logic drive1 = config_q[AXSF_B_OUT_SEL1];
   wire logic drive0 = config_q[AXSF_B_OUT_SEL0];
   wire logic sense1 = config_q[AXSF_B_IN_SEL1] && !drive1;
   wire logic sense0 = config_q[AXSF_B_IN_SEL0] && !drive0;
   // pin readback seen through bits 8, 1, 0
   wire logic level1_rd = sense1 ? bidir1_s : config_q[AXSF_B_LEVEL1];
   wire logic level0_rd = sense0 ? bidir0_s : config_q[AXSF_B_LEVEL0];
   wire logic fault_level_rd = (fault_fn == AXSF_FN_INPUT) ? fault_s : config_q[AXSF_B_FAULT_LEVEL];
   // bits 7,6 are write-only and read as zero
   wire logic [15:0] config_rd = {config_q[15:9], fault_level_rd, 2'b00, config_q[5:2], level1_rd, level0_rd};

   // ****************************************
   // fault flag
   // ****************************************
   // the fault pin is low-active when used as an input
   wire logic pin_fault = (fault_fn == AXSF_FN_INPUT) && !fault_s;
   wire logic fault_d = core_error || pin_fault;

   // ****************************************
   // hold logic
   // ****************************************
   wire logic hold_en = config_q[AXSF_B_HOLD_EN];
   wire logic alt_mode = ctrl_q[AXSF_B_PER_CH_HOLD] && ctrl_q[AXSF_B_MULTI_CH];
   wire logic immediate_reset = hold_en && !alt_mode && !hold_n_s;
   logic stalled_q;
   wire logic due_held = hold_en && alt_mode && channel_switch_due && !hold_n_s;
   wire logic release_start = stalled_q && hold_n_s;
   wire logic start_d = (hold_en && alt_mode) ? ((channel_switch_due && hold_n_s && !stalled_q) || release_start) : channel_switch_due;
   logic fault_prev_q;
   logic hold_prev_q;
   wire logic [AXSF_IRQ_W-1:0] irq_ev = {due_held && !stalled_q, fault_d && !fault_prev_q, immediate_reset && hold_prev_q};

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         config_q <= AXSF_CONFIG_RESET;
         ctrl_q <= 2'b00;
         irq_en_q <= '0;
         irq_stat_q <= '0;
         stalled_q <= 1'b0;
         fault_prev_q <= 1'b0;
         hold_prev_q <= 1'b1;
      end else begin
         if (wr && hit_cfg) begin
            config_q <= pwdata[15:0] & AXSF_CONFIG_WMASK;
         end
         if (wr && hit_ctrl) begin
            ctrl_q <= pwdata[1:0];
         end
         if (wr && hit_en) begin
            irq_en_q <= pwdata[AXSF_IRQ_W-1:0];
         end
         // set wins over clear
         irq_stat_q <= (irq_stat_q & ~((wr && hit_clr) ? pwdata[AXSF_IRQ_W-1:0] : '0)) | irq_ev;
         if (due_held) begin
            stalled_q <= 1'b1;
         end else if (release_start || !(hold_en && alt_mode)) begin
            stalled_q <= 1'b0;
         end
         fault_prev_q <= fault_d;
         hold_prev_q <= !immediate_reset;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         core_reset <= 1'b0;
         conversion_start <= 1'b0;
         fault_status <= 1'b0;
         fault_out <= 1'b0;
         fault_oe <= 1'b0;
         aux_out3 <= 1'b0;
         aux_out2 <= 1'b0;
         aux_bidir1_out <= 1'b0;
         aux_bidir0_out <= 1'b0;
         aux_bidir1_oe <= 1'b0;
         aux_bidir0_oe <= 1'b0;
         irq <= 1'b0;
      end else begin
         // one wait state: answer in the second access cycle
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         prdata <= 32'h0000_0000;
         if (rd && !pready) begin
            if (hit_cfg) prdata <= {16'h0000, config_rd};
            if (hit_id) prdata <= {16'h0000, PART_CODE};
            if (hit_ctrl) prdata <= {30'h0, ctrl_q};
            if (hit_stat) prdata <= {29'h0, irq_stat_q};
            if (hit_en) prdata <= {29'h0, irq_en_q};
         end
         core_reset <= immediate_reset;
         conversion_start <= start_d;
         fault_status <= fault_d;
         case (fault_fn)
            AXSF_FN_OFF: begin
               fault_out <= 1'b0;
               fault_oe <= 1'b0;
            end
            AXSF_FN_INPUT: begin
               fault_out <= 1'b0;
               fault_oe <= 1'b0;
            end
            AXSF_FN_WIRED_OR: begin
               // drive low only on error, let the shared pull-up do the rest
               fault_out <= 1'b0;
               fault_oe <= core_error;
            end
            AXSF_FN_GPO: begin
               fault_out <= config_q[AXSF_B_FAULT_LEVEL];
               fault_oe <= 1'b1;
            end
            default: begin
               fault_out <= 1'b0;
               fault_oe <= 1'b0;
            end
         endcase
         aux_out3 <= config_q[AXSF_B_OUT3];
         aux_out2 <= config_q[AXSF_B_OUT2];
         aux_bidir1_out <= config_q[AXSF_B_LEVEL1];
         aux_bidir0_out <= config_q[AXSF_B_LEVEL0];
         aux_bidir1_oe <= drive1;
         aux_bidir0_oe <= drive0;
         irq <= |(irq_stat_q & irq_en_q);
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence s_held_switch;
      due_held && !stalled_q;
   endsequence
   sequence s_release;
      stalled_q && hold_n_s;
   endsequence
   property p_hold_reset;
      @(posedge clk) disable iff (sys_rst) immediate_reset |=> core_reset;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("hold low did not reset core");
   property p_alt_no_reset;
      @(posedge clk) disable iff (sys_rst) alt_mode |=> !core_reset;
   endproperty
   a_alt_no_reset: assert property (p_alt_no_reset) else $error("per-channel mode reset core");
   property p_stall;
      @(posedge clk) disable iff (sys_rst) s_held_switch |=> !conversion_start ##0 stalled_q;
   endproperty
   a_stall: assert property (p_stall) else $error("conversion started while held");
   property p_release;
      @(posedge clk) disable iff (sys_rst) s_release |=> conversion_start && !stalled_q;
   endproperty
   a_release: assert property (p_release) else $error("release did not start conversion");
   property p_fault_off;
      @(posedge clk) disable iff (sys_rst) (fault_fn == AXSF_FN_OFF) |=> !fault_oe;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("disabled fault pin driven");
   property p_fault_in;
      @(posedge clk) disable iff (sys_rst) (fault_fn == AXSF_FN_INPUT && !fault_s) |=> fault_status;
   endproperty
   a_fault_in: assert property (p_fault_in) else $error("fault input not flagged");
   property p_wired_or;
      @(posedge clk) disable iff (sys_rst) (fault_fn == AXSF_FN_WIRED_OR) |=> fault_oe == $past(core_error) && !fault_out;
   endproperty
   a_wired_or: assert property (p_wired_or) else $error("open-drain fault wrong");
   property p_gpo;
      @(posedge clk) disable iff (sys_rst) (fault_fn == AXSF_FN_GPO) |=> fault_oe && fault_out == $past(config_q[AXSF_B_FAULT_LEVEL]);
   endproperty
   a_gpo: assert property (p_gpo) else $error("fault gpo level wrong");
   property p_both_sel;
      @(posedge clk) disable iff (sys_rst) (config_q[AXSF_B_IN_SEL1] && config_q[AXSF_B_OUT_SEL1]) |=> aux_bidir1_oe;
   endproperty
   a_both_sel: assert property (p_both_sel) else $error("pin1 not driven with both selects");
   property p_ident;
      @(posedge clk) disable iff (sys_rst) (rd && !pready && hit_id) |=> prdata[15:0] == PART_CODE;
   endproperty
   a_ident: assert property (p_ident) else $error("identity read wrong");
   // ****************************************
   // bus, pin, hold and interrupt assertions
   // ****************************************
   property p_answer;
      @(posedge clk) disable iff (sys_rst) (access && !pready) |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after one wait state");
   property p_pready_pulse;
      @(posedge clk) disable iff (sys_rst) pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready stood too long");
   property p_slverr;
      @(posedge clk) disable iff (sys_rst) (access && !pready && !mapped) |=> pready && pslverr && prdata == 32'h0000_0000;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_cfg_write;
      @(posedge clk) disable iff (sys_rst) (wr && hit_cfg) |=> config_q == ($past(pwdata[15:0]) & AXSF_CONFIG_WMASK);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");
   property p_ident_write;
      @(posedge clk) disable iff (sys_rst) (wr && hit_id) |=> config_q == $past(config_q) && ctrl_q == $past(ctrl_q);
   endproperty
   a_ident_write: assert property (p_ident_write) else $error("identity write changed state");
   property p_out_levels;
      @(posedge clk) disable iff (sys_rst) 1'b1 |=> aux_out3 == $past(config_q[AXSF_B_OUT3]) && aux_out2 == $past(config_q[AXSF_B_OUT2]);
   endproperty
   a_out_levels: assert property (p_out_levels) else $error("output-only pin level wrong");
   property p_wo_read;
      @(posedge clk) disable iff (sys_rst) (rd && hit_cfg) |=> prdata[AXSF_B_OUT3:AXSF_B_OUT2] == 2'b00;
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only bits read back");
   property p_bidir_oe;
      @(posedge clk) disable iff (sys_rst) 1'b1 |=> aux_bidir0_oe == $past(config_q[AXSF_B_OUT_SEL0]) && aux_bidir1_oe == $past(config_q[AXSF_B_OUT_SEL1]);
   endproperty
   a_bidir_oe: assert property (p_bidir_oe) else $error("bidir output enable wrong");
   property p_bidir_level;
      @(posedge clk) disable iff (sys_rst) 1'b1 |=> aux_bidir0_out == $past(config_q[AXSF_B_LEVEL0]) && aux_bidir1_out == $past(config_q[AXSF_B_LEVEL1]);
   endproperty
   a_bidir_level: assert property (p_bidir_level) else $error("bidir output level wrong");
   property p_bidir_read;
      @(posedge clk) disable iff (sys_rst) (rd && hit_cfg && config_q[AXSF_B_IN_SEL1] && !config_q[AXSF_B_OUT_SEL1]) |=> prdata[AXSF_B_LEVEL1] == $past(bidir1_s);
   endproperty
   a_bidir_read: assert property (p_bidir_read) else $error("bidir input readback wrong");
   property p_fault_rd;
      @(posedge clk) disable iff (sys_rst) (rd && hit_cfg && fault_fn == AXSF_FN_INPUT) |=> prdata[AXSF_B_FAULT_LEVEL] == $past(fault_s);
   endproperty
   a_fault_rd: assert property (p_fault_rd) else $error("fault pin readback wrong");
   property p_hold_off;
      @(posedge clk) disable iff (sys_rst) !hold_en |=> !core_reset;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("core reset with hold input off");
   property p_single_ch;
      @(posedge clk) disable iff (sys_rst) (hold_en && !ctrl_q[AXSF_B_MULTI_CH] && !hold_n_s) |=> core_reset;
   endproperty
   a_single_ch: assert property (p_single_ch) else $error("single channel hold did not reset");
   property p_plain_start;
      @(posedge clk) disable iff (sys_rst) (!(hold_en && alt_mode) && channel_switch_due) |=> conversion_start;
   endproperty
   a_plain_start: assert property (p_plain_start) else $error("switch did not start conversion");
   property p_irq_set;
      @(posedge clk) disable iff (sys_rst) (|irq_ev) |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("status event lost");
   property p_irq_out;
      @(posedge clk) disable iff (sys_rst) (|(irq_stat_q & irq_en_q)) |=> irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("enabled status did not raise irq");
endmodule
`default_nettype wire

//--- verif/axsf_pins.sv
`timescale 1ns/100ps
`default_nettype none
module axsf_pins (
   // bench controls
   input wire logic hold_lvl,
   input wire logic fault_low,
   input wire logic ext1,
   input wire logic ext0,
   // device pins
   input wire logic fault_out,
   input wire logic fault_oe,
   input wire logic b1_out,
   input wire logic b0_out,
   input wire logic b1_oe,
   input wire logic b0_oe,
   output logic hold_n,
   output logic fault_in,
   output logic b1_in,
   output logic b0_in
);
   assign hold_n = hold_lvl;
   // shared pull-up: any party pulling low wins
   assign fault_in = !(fault_low || (fault_oe && !fault_out));
   // outside party drives only while the device leaves the pin
   assign b1_in = b1_oe ? b1_out : ext1;
   assign b0_in = b0_oe ? b0_out : ext0;
endmodule
`default_nettype wire

//--- verif/test_aux_io_sync_fault_pin_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_aux_io_sync_fault_pin_control;
   import axsf_pkg::*;
   // arbitrary value
   localparam logic [15:0] CODE = 16'h3a5c;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [5:0] paddr = 6'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic err, pready, pslverr, core_error = 1'b0, sw_due = 1'b0, core_reset, conv_start, fault_status;
   logic hold_n, fault_in, fault_out, fault_oe, out3, out2, b1_in, b0_in, b1_out, b0_out, b1_oe, b0_oe, irq;
   logic hold_lvl = 1'b1, fault_low = 1'b0, ext1 = 1'b0, ext0 = 1'b0;
   int bad_count = 0, cmp_count = 0, cycles = 0, starts = 0, n;
   axsf_top #(.PART_CODE(CODE)) axsf_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_error(core_error), .channel_switch_due(sw_due),
      .core_reset(core_reset), .conversion_start(conv_start), .fault_status(fault_status),
      .hold_n_in(hold_n), .fault_in(fault_in), .fault_out(fault_out), .fault_oe(fault_oe),
      .aux_out3(out3), .aux_out2(out2), .aux_bidir1_in(b1_in), .aux_bidir0_in(b0_in),
      .aux_bidir1_out(b1_out), .aux_bidir0_out(b0_out), .aux_bidir1_oe(b1_oe),
      .aux_bidir0_oe(b0_oe), .irq(irq));
   axsf_pins axsf_pins_inst (.hold_lvl(hold_lvl), .fault_low(fault_low), .ext1(ext1), .ext0(ext0),
      .fault_out(fault_out), .fault_oe(fault_oe), .b1_out(b1_out), .b0_out(b0_out), .b1_oe(b1_oe),
      .b0_oe(b0_oe), .hold_n(hold_n), .fault_in(fault_in), .b1_in(b1_in), .b0_in(b0_in));
   always #50 clk = ~clk;
   task automatic summarize();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (conv_start === 1'b1) begin
         starts <= starts + 1;
      end
      // whole run needs well under a thousand cycles
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(6'h18, 32'h0800);
      chk({31'h0, err}, 32'h0);
      chk({29'h0, b1_oe, b0_oe, fault_oe}, 32'h0);
      rdc(6'h1c, {16'h0, CODE});
      apb(1'b1, 6'h1c, 32'h1234);
      rdc(6'h1c, {16'h0, CODE});
      rdc(6'h3c, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 6'h18, 32'h0880);
      wt(2);
      chk({30'h0, out3, out2}, 32'h2);
      rdc(6'h18, 32'h0800);
      apb(1'b1, 6'h18, 32'h0840);
      wt(2);
      chk({30'h0, out3, out2}, 32'h1);
      // pin0 both selects, pin1 input
      ext1 <= 1'b1;
      apb(1'b1, 6'h18, 32'h0835);
      wt(5);
      chk({29'h0, b1_oe, b0_oe, b0_out}, 32'h3);
      rdc(6'h18, 32'h0837);
      ext1 <= 1'b0;
      wt(5);
      rdc(6'h18, 32'h0835);
      apb(1'b1, 6'h18, 32'h080a);
      wt(2);
      chk({30'h0, b1_oe, b1_out}, 32'h3);
      // fault pin as input
      apb(1'b1, 6'h18, 32'h0a00);
      fault_low <= 1'b1;
      wt(5);
      chk({31'h0, fault_status}, 32'h1);
      rdc(6'h18, 32'h0a00);
      fault_low <= 1'b0;
      wt(5);
      chk({31'h0, fault_status}, 32'h0);
      rdc(6'h18, 32'h0b00);
      core_error <= 1'b1;
      wt(4);
      chk({31'h0, fault_status}, 32'h1);
      apb(1'b1, 6'h18, 32'h0c00);
      wt(3);
      chk({29'h0, fault_oe, fault_out, fault_in}, 32'h4);
      core_error <= 1'b0;
      wt(3);
      chk({31'h0, fault_oe}, 32'h0);
      apb(1'b1, 6'h18, 32'h0f00);
      wt(2);
      chk({30'h0, fault_oe, fault_out}, 32'h3);
      apb(1'b1, 6'h18, 32'h0e00);
      wt(2);
      chk({30'h0, fault_oe, fault_out}, 32'h2);
      apb(1'b1, 6'h18, 32'h0800);
      wt(2);
      chk({31'h0, fault_oe}, 32'h0);
      // immediate hold
      hold_lvl <= 1'b0;
      wt(5);
      chk({31'h0, core_reset}, 32'h1);
      hold_lvl <= 1'b1;
      wt(5);
      chk({31'h0, core_reset}, 32'h0);
      // hold and fault rises both left a sticky status bit
      rdc(6'h24, 32'h3);
      // per-channel mode with one channel: hold still resets
      apb(1'b1, 6'h20, 32'h1);
      hold_lvl <= 1'b0;
      wt(5);
      chk({31'h0, core_reset}, 32'h1);
      hold_lvl <= 1'b1;
      wt(5);
      n = starts;
      sw_due <= 1'b1;
      @(posedge clk);
      sw_due <= 1'b0;
      wt(3);
      chk(starts, n + 1);
      // per-channel hold with stall interrupt
      apb(1'b1, 6'h2c, 32'h7);
      apb(1'b1, 6'h28, 32'h4);
      apb(1'b1, 6'h20, 32'h3);
      hold_lvl <= 1'b0;
      wt(5);
      chk({31'h0, core_reset}, 32'h0);
      n = starts;
      sw_due <= 1'b1;
      @(posedge clk);
      sw_due <= 1'b0;
      wt(6);
      chk(starts, n);
      chk({31'h0, irq}, 32'h1);
      rdc(6'h24, 32'h4);
      apb(1'b1, 6'h28, 32'h0);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 6'h28, 32'h4);
      hold_lvl <= 1'b1;
      wt(8);
      chk(starts, n + 1);
      apb(1'b1, 6'h2c, 32'h4);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      rdc(6'h24, 32'h0);
      // hold input switched off: a low pin must not reset
      apb(1'b1, 6'h20, 32'h0);
      apb(1'b1, 6'h18, 32'h0);
      hold_lvl <= 1'b0;
      wt(5);
      chk({31'h0, core_reset}, 32'h0);
      hold_lvl <= 1'b1;
      summarize();
   end
endmodule
`default_nettype wire
